// ==== verilog/obdcfg_pkg.sv ====
// How it works
// R1: data limited to seven bytes each way; long mode sends eight, receives unlimited.
// R2: accept and show a reply only when its destination equals the receive address.
// R3: automatic mode derives the receive address from headers, not under J1939.
// R4: adaptive timeout follows measured replies and never exceeds the programmed timeout.
// R5: three adaptive settings: off, normal (default), aggressive.
// R6: under J1939 adaptive timing is ignored and a fixed timeout applies.
// R7: every message is stored; only its first twelve bytes are kept.
// R8: a dump request, any time, outputs a length byte then twelve buffer bytes; a request during a running dump is ignored.
// R9: the length byte is the true received count modulo 256.
// R10: skip-init activates the protocol with no initiation or handshake.
// R11: trial rate is 4000 kbps divided by the divisor argument.
// R12: divisor request: OK at old rate, wait, identity at new rate, await reply.
// R13: host checks the identity and sends one carriage return only if error-free.
// R14: carriage return keeps the new rate; silence until timeout reverts it.
// R15: adopted rate survives defaults and warm restart, not reset or full reset.
// R16: handshake timeout is argument times 5.0 ms, default 0F, 00 means 256.
// R17: auto-format inserts PCI, strips PCI and padding, drops bad PCI unless monitoring.
// R18: multi-frame replies print total length, then numbered segments.
// R19: a First Frame triggers a Flow Control when flow-control-auto is on.
// R20: remote frames hidden with auto-format on, printed as RTR when off.
// R21: auto-format off prints all bytes, sends host bytes, pads to eight.
// R22: headers shown with auto-format prints raw; sending still adds PCI and padding.
// R23: commands run after the carriage return; setting changes answer OK.
// R24: flow-control-auto defaults on; no flow control while monitoring.
package obdcfg_pkg;
   localparam int         CLK_MHZ        = 100;
   localparam int         HS_STEP_US     = 5000;  // 5.0 ms
   localparam int         HS_STEP_CYCLES = HS_STEP_US * CLK_MHZ;
   localparam int         SWITCH_US      = 2000;
   localparam int         SWITCH_CYCLES  = SWITCH_US * CLK_MHZ;
   localparam int         BUF_DEPTH      = 12;
   localparam logic [7:0] HS_ARG_DFLT    = 8'h0F;
   localparam logic [8:0] HS_STEPS_MAX   = 9'h100;
   localparam logic [7:0] RESP_TO_DFLT   = 8'h32;
   localparam logic [7:0] J1939_TO       = 8'h4B;
   localparam logic [7:0] DIV_DFLT       = 8'h68;
   localparam logic [7:0] RX_ADDR_DFLT   = 8'hF1;
   localparam logic [3:0] STD_MAX        = 4'h7;
   localparam logic [3:0] LONG_MAX       = 4'h8;
   localparam logic [4:0] CAN_BYTES      = 5'h08;
   localparam logic [3:0] PCI_SINGLE     = 4'h0;
   localparam logic [3:0] PCI_FIRST      = 4'h1;
   localparam logic [3:0] PCI_CONSEC     = 4'h2;
   localparam logic [3:0] PCI_FLOW       = 4'h3;
   typedef enum logic [4:0] {
      CMD_LONG_MESSAGE_ENABLE  = 5'h00, CMD_STANDARD_LENGTH_MODE = 5'h01,
      CMD_AUTOMATIC_RX_ADDRESS = 5'h02, CMD_SET_RX_ADDRESS       = 5'h03,
      CMD_RESPONSE_TIMEOUT     = 5'h04, CMD_ADAPTIVE_OFF         = 5'h05,
      CMD_ADAPTIVE_NORMAL      = 5'h06, CMD_ADAPTIVE_AGGRESSIVE  = 5'h07,
      CMD_HISTORY_DUMP         = 5'h08, CMD_SKIP_INIT            = 5'h09,
      CMD_SERIAL_DIVISOR_TRY   = 5'h0A, CMD_RATE_HS_TIMEOUT      = 5'h0B,
      CMD_AUTOFORMAT_OFF       = 5'h0C, CMD_AUTOFORMAT_ON        = 5'h0D,
      CMD_FLOW_AUTO_OFF        = 5'h0E, CMD_FLOW_AUTO_ON         = 5'h0F,
      CMD_SHOW_HEADERS_OFF     = 5'h10, CMD_SHOW_HEADERS_ON      = 5'h11,
      CMD_RESTORE_DEFAULTS     = 5'h12, CMD_WARM_RESTART         = 5'h13,
      CMD_FULL_RESET           = 5'h14
   } obdcfg_cmd_e;
   typedef enum logic [1:0] {
      ADAPT_OFF = 2'h0, ADAPT_NORMAL = 2'h1, ADAPT_AGGR = 2'h2
   } obdcfg_adapt_e;
   typedef enum logic [1:0] {
      HS_IDLE = 2'h0, HS_SWITCH = 2'h1, HS_AWAIT = 2'h2
   } obdcfg_hs_e;
   typedef enum logic [1:0] {
      DMP_IDLE = 2'h0, DMP_LEN = 2'h1, DMP_DATA = 2'h2
   } obdcfg_dmp_e;
endpackage

// ==== verilog/obdcfg_core.sv ====
module obdcfg_core #(
   parameter int HS_STEP_CYCLES = obdcfg_pkg::HS_STEP_CYCLES,
   parameter int SWITCH_CYCLES  = obdcfg_pkg::SWITCH_CYCLES
) (
   // clock, reset, enable
   input  wire logic        CLK_SYS,
   input  wire logic        RST,
   input  wire logic        CE,
   // parsed command, presented once its carriage return is seen
   input  wire logic        CMD_VALID,
   input  wire logic [4:0]  CMD_CODE,
   input  wire logic [7:0]  CMD_ARG,
   output logic             CMD_OK,
   output logic             CMD_ERR,
   // protocol context
   input  wire logic        PROTO_J1939,
   input  wire logic        MONITOR,
   input  wire logic        HDR_CHANGED,
   input  wire logic [7:0]  HDR_SOURCE,
   output logic             PROTO_UP_NOINIT,
   // vehicle messages
   input  wire logic        RX_MSG_START,
   input  wire logic [7:0]  RX_DEST,
   output logic             RX_ACCEPT,
   output logic [7:0]       RX_ADDR,
   input  wire logic        MSG_START,
   input  wire logic        MSG_BYTE_VALID,
   input  wire logic        MSG_IS_RX,
   input  wire logic [7:0]  MSG_BYTE,
   output logic             RX_TOO_LONG,
   output logic             LONG_MESSAGE_ENABLE,
   // send request
   input  wire logic        TX_REQ,
   input  wire logic [3:0]  TX_LEN,
   output logic             TX_ACCEPT,
   output logic             TX_ADD_PCI,
   output logic [4:0]       TX_PAD,
   // response timing
   input  wire logic        RESP_SEEN,
   input  wire logic [7:0]  RESP_TIME,
   output logic [7:0]       TIMEOUT_EFF,
   // history dump stream
   input  wire logic        DUMP_READY,
   output logic             DUMP_VALID,
   output logic [7:0]       DUMP_BYTE,
   // serial rate trial
   input  wire logic        HOST_CR,
   output logic [7:0]       BAUD_DIV,
   output logic             SEND_ID,
   // CAN frame received
   input  wire logic        CAN_FRAME,
   input  wire logic        CAN_RTR,
   input  wire logic [3:0]  CAN_DLC,
   input  wire logic [7:0]  CAN_PCI,
   input  wire logic [7:0]  CAN_PCI_NEXT,
   output logic             CAN_AUTOFORMAT,
   output logic             CAN_PRINT,
   output logic             CAN_STRIP,
   output logic             CAN_DATA_ERR,
   output logic             CAN_RTR_PRINT,
   output logic             CAN_LEN_LINE,
   output logic [11:0]      CAN_TOTAL_LEN,
   output logic             CAN_SEG,
   output logic [3:0]       CAN_SEG_NUM,
   output logic             CAN_SEND_FC
);

   obdcfg_pkg::obdcfg_cmd_e   cmd;
   obdcfg_pkg::obdcfg_adapt_e adapt_mode;
   obdcfg_pkg::obdcfg_hs_e    hs_state;
   obdcfg_pkg::obdcfg_dmp_e   dmp_state;

   logic        cmd_go;
   logic        soft_dflt;
   logic        div_rst;
   logic        automatic_rx_address;
   logic        flow_control_auto;
   logic        show_headers;
   logic [7:0]  response_timeout;
   logic [7:0]  hs_arg;
   logic [7:0]  hist [obdcfg_pkg::BUF_DEPTH];
   logic [7:0]  hist_cnt;
   logic [3:0]  dmp_idx;
   logic [7:0]  base_div;
   logic [7:0]  trial_div;
   logic [23:0] hs_cnt;
   logic [8:0]  hs_steps;
   logic        pci_ok;
   logic        fmt_rx;
   logic [7:0]  adapt_tgt;

   function automatic logic [7:0] min8(input logic [7:0] a, input logic [7:0] b);
      min8 = (a < b) ? a : b;
   endfunction

   function automatic logic pci_valid(input logic [7:0] pci, input logic [3:0] dlc);
      unique case (pci[7:4])
         obdcfg_pkg::PCI_SINGLE: pci_valid = (pci[3:0] != 4'h0) &&
                                             (pci[3:0] <= obdcfg_pkg::STD_MAX) &&
                                             (pci[3:0] < dlc);
         obdcfg_pkg::PCI_FIRST:  pci_valid = (dlc == obdcfg_pkg::LONG_MAX);
         obdcfg_pkg::PCI_CONSEC: pci_valid = 1'b1;
         obdcfg_pkg::PCI_FLOW:   pci_valid = 1'b1;
         default:                pci_valid = 1'b0;
      endcase
   endfunction

   assign cmd       = obdcfg_pkg::obdcfg_cmd_e'(CMD_CODE);
   assign cmd_go    = CE && CMD_VALID; // R23
   // a trial rate survives defaults and warm restart, only reset or full reset drop it
   assign div_rst   = RST || (cmd_go && cmd == obdcfg_pkg::CMD_FULL_RESET); // R15
   assign soft_dflt = div_rst || (cmd_go && (cmd == obdcfg_pkg::CMD_RESTORE_DEFAULTS ||
                                             cmd == obdcfg_pkg::CMD_WARM_RESTART));
   assign pci_ok    = pci_valid(CAN_PCI, CAN_DLC);
   // shown headers override the receive-side formatting of data frames only; remote frames follow CAN_AUTOFORMAT
   assign fmt_rx    = CAN_AUTOFORMAT && !show_headers; // R22
   // aggressive settles closer to the measured time
   assign adapt_tgt = (adapt_mode == obdcfg_pkg::ADAPT_AGGR) ?
                      min8(8'hFF - (RESP_TIME >> 3), RESP_TIME) + (RESP_TIME >> 3) :
                      min8(8'hFF - (RESP_TIME >> 1), RESP_TIME) + (RESP_TIME >> 1);

   // settings
   always_ff @(posedge CLK_SYS) begin
      if (soft_dflt) begin
         LONG_MESSAGE_ENABLE  <= 1'b0; // R1
         automatic_rx_address <= 1'b1;
         adapt_mode           <= obdcfg_pkg::ADAPT_NORMAL; // R5
         response_timeout     <= obdcfg_pkg::RESP_TO_DFLT;
         hs_arg               <= obdcfg_pkg::HS_ARG_DFLT; // R16
         CAN_AUTOFORMAT       <= 1'b1; // R22
         flow_control_auto    <= 1'b1; // R24
         show_headers         <= 1'b0;
      end else if (cmd_go) begin
         unique case (cmd)
            obdcfg_pkg::CMD_LONG_MESSAGE_ENABLE:  LONG_MESSAGE_ENABLE  <= 1'b1; // R1
            obdcfg_pkg::CMD_STANDARD_LENGTH_MODE: LONG_MESSAGE_ENABLE  <= 1'b0;
            obdcfg_pkg::CMD_AUTOMATIC_RX_ADDRESS: automatic_rx_address <= 1'b1;
            obdcfg_pkg::CMD_SET_RX_ADDRESS:       automatic_rx_address <= 1'b0;
            obdcfg_pkg::CMD_RESPONSE_TIMEOUT:     response_timeout     <= CMD_ARG;
            obdcfg_pkg::CMD_ADAPTIVE_OFF:         adapt_mode <= obdcfg_pkg::ADAPT_OFF; // R5
            obdcfg_pkg::CMD_ADAPTIVE_NORMAL:      adapt_mode <= obdcfg_pkg::ADAPT_NORMAL;
            obdcfg_pkg::CMD_ADAPTIVE_AGGRESSIVE:  adapt_mode <= obdcfg_pkg::ADAPT_AGGR;
            obdcfg_pkg::CMD_RATE_HS_TIMEOUT:      hs_arg               <= CMD_ARG;
            obdcfg_pkg::CMD_AUTOFORMAT_OFF:       CAN_AUTOFORMAT       <= 1'b0;
            obdcfg_pkg::CMD_AUTOFORMAT_ON:        CAN_AUTOFORMAT       <= 1'b1;
            obdcfg_pkg::CMD_FLOW_AUTO_OFF:        flow_control_auto    <= 1'b0;
            obdcfg_pkg::CMD_FLOW_AUTO_ON:         flow_control_auto    <= 1'b1;
            obdcfg_pkg::CMD_SHOW_HEADERS_OFF:     show_headers         <= 1'b0;
            obdcfg_pkg::CMD_SHOW_HEADERS_ON:      show_headers         <= 1'b1;
            default: ;
         endcase
      end
   end

   // command answers: the trial gets its OK here, before any rate change
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         CMD_OK          <= 1'b0;
         CMD_ERR         <= 1'b0;
         PROTO_UP_NOINIT <= 1'b0;
      end else if (CE) begin
         CMD_OK          <= 1'b0;
         CMD_ERR         <= 1'b0;
         PROTO_UP_NOINIT <= 1'b0;
         if (CMD_VALID) begin
            if (CMD_CODE > obdcfg_pkg::CMD_FULL_RESET ||
                (cmd == obdcfg_pkg::CMD_SERIAL_DIVISOR_TRY &&
                 (CMD_ARG == 8'h00 || hs_state != obdcfg_pkg::HS_IDLE)))
               CMD_ERR <= 1'b1;
            else if (cmd != obdcfg_pkg::CMD_HISTORY_DUMP)
               CMD_OK <= 1'b1; // R23 R12
            PROTO_UP_NOINIT <= (cmd == obdcfg_pkg::CMD_SKIP_INIT); // R10
         end
      end
   end

   // receive address
   always_ff @(posedge CLK_SYS) begin
      if (soft_dflt) begin
         RX_ADDR <= obdcfg_pkg::RX_ADDR_DFLT;
      end else if (cmd_go && cmd == obdcfg_pkg::CMD_SET_RX_ADDRESS) begin
         RX_ADDR <= CMD_ARG;
      end else if (CE && automatic_rx_address && !PROTO_J1939 &&
                   (HDR_CHANGED || (cmd_go && cmd == obdcfg_pkg::CMD_AUTOMATIC_RX_ADDRESS))) begin
         RX_ADDR <= HDR_SOURCE; // R3
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         RX_ACCEPT <= 1'b0;
      end else if (CE) begin
         RX_ACCEPT <= RX_MSG_START && (RX_DEST == RX_ADDR); // R2
      end
   end

   // send length check and padding
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         TX_ACCEPT  <= 1'b0;
         TX_ADD_PCI <= 1'b0;
         TX_PAD     <= 5'h00;
      end else if (CE) begin
         TX_ACCEPT <= 1'b0;
         if (TX_REQ) begin
            TX_ACCEPT  <= (TX_LEN != 4'h0) && (TX_LEN <= (LONG_MESSAGE_ENABLE ?
                          obdcfg_pkg::LONG_MAX : obdcfg_pkg::STD_MAX)); // R1
            TX_ADD_PCI <= CAN_AUTOFORMAT; // R17 R22
            // trailing padding fills the frame to eight bytes in either mode
            if ({1'b0, TX_LEN} + {4'h0, CAN_AUTOFORMAT} <= obdcfg_pkg::CAN_BYTES)
               TX_PAD <= obdcfg_pkg::CAN_BYTES - {1'b0, TX_LEN} - {4'h0, CAN_AUTOFORMAT}; // R21
            else
               TX_PAD <= 5'h00;
         end
      end
   end

   // adaptive response timeout
   always_ff @(posedge CLK_SYS) begin
      if (soft_dflt) begin
         TIMEOUT_EFF <= obdcfg_pkg::RESP_TO_DFLT;
      end else if (CE) begin
         if (PROTO_J1939)
            TIMEOUT_EFF <= obdcfg_pkg::J1939_TO; // R6
         else if (adapt_mode == obdcfg_pkg::ADAPT_OFF)
            TIMEOUT_EFF <= response_timeout; // R5
         else if (RESP_SEEN && adapt_mode == obdcfg_pkg::ADAPT_AGGR)
            TIMEOUT_EFF <= min8(adapt_tgt, response_timeout); // R4
         else if (RESP_SEEN)
            TIMEOUT_EFF <= min8(8'((({1'b0, TIMEOUT_EFF} + {1'b0, adapt_tgt}) >> 1)),
                                response_timeout); // R4
         else if (TIMEOUT_EFF > response_timeout)
            TIMEOUT_EFF <= response_timeout; // R4
      end
   end

   // message history; the count keeps running past the stored bytes
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         hist_cnt    <= 8'h00;
         RX_TOO_LONG <= 1'b0;
      end else if (CE) begin
         RX_TOO_LONG <= 1'b0;
         if (MSG_START) begin
            hist_cnt <= 8'h00;
         end else if (MSG_BYTE_VALID) begin
            hist_cnt <= hist_cnt + 8'h01; // R9
            RX_TOO_LONG <= MSG_IS_RX && !LONG_MESSAGE_ENABLE &&
                           (hist_cnt >= 8'(obdcfg_pkg::STD_MAX)); // R1
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (CE && !MSG_START && MSG_BYTE_VALID && hist_cnt < 8'(obdcfg_pkg::BUF_DEPTH))
         hist[4'(hist_cnt)] <= MSG_BYTE; // R7
   end

   // dump: length byte, then every location
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         dmp_state  <= obdcfg_pkg::DMP_IDLE;
         dmp_idx    <= 4'h0;
         DUMP_VALID <= 1'b0;
         DUMP_BYTE  <= 8'h00;
      end else if (CE) begin
         unique case (dmp_state)
            obdcfg_pkg::DMP_IDLE: if (CMD_VALID && cmd == obdcfg_pkg::CMD_HISTORY_DUMP) begin
               dmp_state  <= obdcfg_pkg::DMP_LEN; // R8
               DUMP_VALID <= 1'b1;
               DUMP_BYTE  <= hist_cnt; // R9
            end
            obdcfg_pkg::DMP_LEN: if (DUMP_READY) begin
               dmp_state <= obdcfg_pkg::DMP_DATA;
               dmp_idx   <= 4'h0;
               DUMP_BYTE <= hist[0];
            end
            obdcfg_pkg::DMP_DATA: if (DUMP_READY) begin
               if (dmp_idx == 4'(obdcfg_pkg::BUF_DEPTH - 1)) begin
                  dmp_state  <= obdcfg_pkg::DMP_IDLE; // R8
                  DUMP_VALID <= 1'b0;
               end else begin
                  dmp_idx   <= dmp_idx + 4'h1;
                  DUMP_BYTE <= hist[dmp_idx + 4'h1];
               end
            end
            default: dmp_state <= obdcfg_pkg::DMP_IDLE;
         endcase
      end
   end

   // serial rate trial; the uart divides its 4000 kbps base by BAUD_DIV
   always_ff @(posedge CLK_SYS) begin
      if (div_rst) begin
         hs_state  <= obdcfg_pkg::HS_IDLE;
         BAUD_DIV  <= obdcfg_pkg::DIV_DFLT; // R15
         base_div  <= obdcfg_pkg::DIV_DFLT;
         trial_div <= obdcfg_pkg::DIV_DFLT;
         hs_cnt    <= 24'h000000;
         hs_steps  <= 9'h000;
         SEND_ID   <= 1'b0;
      end else if (CE) begin
         SEND_ID <= 1'b0;
         unique case (hs_state)
            obdcfg_pkg::HS_IDLE:
               if (CMD_VALID && cmd == obdcfg_pkg::CMD_SERIAL_DIVISOR_TRY && CMD_ARG != 8'h00) begin
                  trial_div <= CMD_ARG; // R11
                  hs_cnt    <= 24'(SWITCH_CYCLES - 1); // R12
                  hs_state  <= obdcfg_pkg::HS_SWITCH;
               end
            obdcfg_pkg::HS_SWITCH:
               if (hs_cnt == 24'h000000) begin
                  BAUD_DIV <= trial_div; // R11 R12
                  SEND_ID  <= 1'b1; // R12
                  hs_cnt   <= 24'(HS_STEP_CYCLES - 1);
                  hs_steps <= (hs_arg == 8'h00) ? obdcfg_pkg::HS_STEPS_MAX : {1'b0, hs_arg}; // R16
                  hs_state <= obdcfg_pkg::HS_AWAIT;
               end else begin
                  hs_cnt <= hs_cnt - 24'h000001;
               end
            obdcfg_pkg::HS_AWAIT:
               if (HOST_CR) begin // R13
                  base_div <= BAUD_DIV; // R14
                  hs_state <= obdcfg_pkg::HS_IDLE;
               end else if (hs_cnt != 24'h000000) begin
                  hs_cnt <= hs_cnt - 24'h000001;
               end else if (hs_steps == 9'h001) begin
                  BAUD_DIV <= base_div; // R14
                  hs_state <= obdcfg_pkg::HS_IDLE;
               end else begin
                  hs_steps <= hs_steps - 9'h001; // R16
                  hs_cnt   <= 24'(HS_STEP_CYCLES - 1);
               end
            default: hs_state <= obdcfg_pkg::HS_IDLE;
         endcase
      end
   end

   // CAN frame handling
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         CAN_PRINT     <= 1'b0;
         CAN_STRIP     <= 1'b0;
         CAN_DATA_ERR  <= 1'b0;
         CAN_RTR_PRINT <= 1'b0;
         CAN_LEN_LINE  <= 1'b0;
         CAN_TOTAL_LEN <= 12'h000;
         CAN_SEG       <= 1'b0;
         CAN_SEG_NUM   <= 4'h0;
         CAN_SEND_FC   <= 1'b0;
      end else if (CE) begin
         CAN_PRINT     <= 1'b0;
         CAN_STRIP     <= 1'b0;
         CAN_DATA_ERR  <= 1'b0;
         CAN_RTR_PRINT <= 1'b0;
         CAN_LEN_LINE  <= 1'b0;
         CAN_SEG       <= 1'b0;
         CAN_SEND_FC   <= 1'b0;
         if (CAN_FRAME && CAN_RTR) begin
            CAN_PRINT     <= !CAN_AUTOFORMAT; // R20
            CAN_RTR_PRINT <= !CAN_AUTOFORMAT; // R20
         end else if (CAN_FRAME) begin
            CAN_PRINT    <= !fmt_rx || pci_ok || MONITOR; // R17 R21 R22
            CAN_STRIP    <= fmt_rx && pci_ok; // R17
            CAN_DATA_ERR <= fmt_rx && !pci_ok && MONITOR; // R17
            if (fmt_rx && pci_ok && CAN_PCI[7:4] == obdcfg_pkg::PCI_FIRST) begin
               CAN_LEN_LINE  <= 1'b1; // R18
               CAN_TOTAL_LEN <= {CAN_PCI[3:0], CAN_PCI_NEXT};
               CAN_SEG       <= 1'b1;
               CAN_SEG_NUM   <= 4'h0;
            end
            if (fmt_rx && pci_ok && CAN_PCI[7:4] == obdcfg_pkg::PCI_CONSEC) begin
               CAN_SEG     <= 1'b1; // R18
               CAN_SEG_NUM <= CAN_PCI[3:0];
            end
            // no flow control while monitoring, whatever the format setting
            CAN_SEND_FC <= flow_control_auto && !MONITOR &&
                           CAN_PCI[7:4] == obdcfg_pkg::PCI_FIRST; // R19 R24
         end
      end
   end

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);

   sequence s_dump_req;
      CE && CMD_VALID && cmd == obdcfg_pkg::CMD_HISTORY_DUMP &&
      dmp_state == obdcfg_pkg::DMP_IDLE;
   endsequence
   sequence s_try;
      CE && CMD_VALID && cmd == obdcfg_pkg::CMD_SERIAL_DIVISOR_TRY && CMD_ARG != 8'h00 &&
      hs_state == obdcfg_pkg::HS_IDLE;
   endsequence

   property p_tx_len;
      CE && TX_REQ && !LONG_MESSAGE_ENABLE && TX_LEN > obdcfg_pkg::STD_MAX |=> !TX_ACCEPT;
   endproperty
   a_tx_len: assert property (p_tx_len) else $error("overlong send accepted"); // R1
   property p_rx_match;
      CE && RX_MSG_START |=> RX_ACCEPT == $past(RX_DEST == RX_ADDR);
   endproperty
   a_rx_match: assert property (p_rx_match) else $error("receive address misjudged"); // R2
   property p_auto_rx;
      CE && automatic_rx_address && !PROTO_J1939 && HDR_CHANGED && !CMD_VALID
      |=> RX_ADDR == $past(HDR_SOURCE);
   endproperty
   a_auto_rx: assert property (p_auto_rx) else $error("receive address not derived"); // R3
   property p_eff_cap;
      CE && RESP_SEEN && !PROTO_J1939 && !CMD_VALID |=> TIMEOUT_EFF <= $past(response_timeout);
   endproperty
   a_eff_cap: assert property (p_eff_cap) else $error("timeout above programmed value"); // R4
   property p_j1939;
      CE && PROTO_J1939 && !CMD_VALID |=> TIMEOUT_EFF == obdcfg_pkg::J1939_TO;
   endproperty
   a_j1939: assert property (p_j1939) else $error("fixed timeout not applied"); // R6
   property p_dump;
      s_dump_req |=> DUMP_VALID && DUMP_BYTE == $past(hist_cnt);
   endproperty
   a_dump: assert property (p_dump) else $error("dump length byte wrong"); // R9
   property p_hs_ok;
      s_try |=> CMD_OK && BAUD_DIV == $past(BAUD_DIV) ##1 BAUD_DIV == $past(BAUD_DIV, 2);
   endproperty
   a_hs_ok: assert property (p_hs_ok) else $error("rate changed before OK"); // R12
   property p_hs_revert;
      CE && hs_state == obdcfg_pkg::HS_AWAIT && !HOST_CR && hs_cnt == 24'h000000 &&
      hs_steps == 9'h001 && !div_rst |=> BAUD_DIV == $past(base_div);
   endproperty
   a_hs_revert: assert property (p_hs_revert) else $error("no fall-back on timeout"); // R14
   property p_fc_mon;
      CE && CAN_FRAME && MONITOR |=> !CAN_SEND_FC;
   endproperty
   a_fc_mon: assert property (p_fc_mon) else $error("flow control while monitoring"); // R24
   property p_rtr;
      CE && CAN_FRAME && CAN_RTR |=> CAN_RTR_PRINT == !$past(CAN_AUTOFORMAT);
   endproperty
   a_rtr: assert property (p_rtr) else $error("remote frame display wrong"); // R20

endmodule

// ==== verif/obdcfg_host_model.sv ====
module obdcfg_host_model (
   // clock
   input  wire logic CLK_SYS,
   // identity seen, host verdict
   input  wire logic SEND_ID,
   input  wire logic ANSWER,
   // carriage return toward the device
   output logic      HOST_CR
);
   timeunit 1ns;
   timeprecision 1ps;
   // one process owns the line; a host that saw a garbled identity stays silent
   initial begin
      HOST_CR = 1'b0;
      forever begin
         @(posedge CLK_SYS iff SEND_ID === 1'b1);
         if (ANSWER) begin
            repeat (3) @(negedge CLK_SYS);
            HOST_CR = 1'b1;
            @(negedge CLK_SYS);
            HOST_CR = 1'b0;
         end
      end
   end
endmodule

// ==== verif/test_obd_bridge_setup_commands.sv ====
module test_obd_bridge_setup_commands;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLK_SYS = 0, RST = 1, CE = 1, CMD_VALID = 0, PROTO_J1939 = 0, MONITOR = 0;
   logic HDR_CHANGED = 0, RX_MSG_START = 0, MSG_START = 0, MSG_BYTE_VALID = 0;
   logic MSG_IS_RX = 1, TX_REQ = 0, RESP_SEEN = 0, DUMP_READY = 1, CAN_FRAME = 0;
   logic CAN_RTR = 0, host_ok = 0;
   logic [4:0] CMD_CODE = 0;
   logic [3:0] TX_LEN = 0, CAN_DLC = 0;
   logic [7:0] CMD_ARG = 0, HDR_SOURCE = 0, RX_DEST = 0, MSG_BYTE = 0, RESP_TIME = 0;
   logic [7:0] CAN_PCI = 0, CAN_PCI_NEXT = 0;
   logic CMD_OK, CMD_ERR, PROTO_UP_NOINIT, RX_ACCEPT, RX_TOO_LONG, LONG_MESSAGE_ENABLE;
   logic TX_ACCEPT, TX_ADD_PCI, DUMP_VALID, SEND_ID, CAN_AUTOFORMAT, CAN_PRINT, CAN_STRIP;
   logic CAN_DATA_ERR, CAN_RTR_PRINT, CAN_LEN_LINE, CAN_SEG, CAN_SEND_FC, HOST_CR;
   logic [7:0] RX_ADDR, TIMEOUT_EFF, DUMP_BYTE, BAUD_DIV;
   logic [4:0] TX_PAD;
   logic [11:0] CAN_TOTAL_LEN;
   logic [3:0] CAN_SEG_NUM;
   int n_errors = 0, samples_checked = 0, i, k;
   // long counts shortened so a trial fits in a few dozen cycles
   obdcfg_core #(.HS_STEP_CYCLES(8), .SWITCH_CYCLES(4)) dut_u (.*);
   obdcfg_host_model host_u (.CLK_SYS(CLK_SYS), .SEND_ID(SEND_ID), .ANSWER(host_ok),
                             .HOST_CR(HOST_CR));
   always #5 CLK_SYS = ~CLK_SYS;
   task chk(input string n, input logic [11:0] s, input logic [11:0] e);
      samples_checked++;
      if (s !== e) begin
         n_errors++;
         $display("BAD %s exp %h seen %h", n, e, s);
      end
   endtask
   task cmd(input logic [4:0] c, input logic [7:0] a);
      @(negedge CLK_SYS);
      CMD_VALID = 1;
      CMD_CODE = c;
      CMD_ARG = a;
      @(negedge CLK_SYS);
      CMD_VALID = 0;
   endtask
   task can(input logic r, input logic [7:0] p);
      @(negedge CLK_SYS);
      {CAN_FRAME, CAN_RTR, CAN_DLC, CAN_PCI, CAN_PCI_NEXT} = {1'b1, r, 4'h8, p, 8'h14};
      @(negedge CLK_SYS);
      CAN_FRAME = 0;
   endtask
   task summarize;
      $display("checked %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (2000) @(posedge CLK_SYS);
      n_errors++;
      summarize();
   end
   initial begin
      repeat (4) @(negedge CLK_SYS);
      RST = 0;
      chk("long", LONG_MESSAGE_ENABLE, 0);
      chk("fmt", CAN_AUTOFORMAT, 1);
      cmd(5'h00, 0);
      chk("ok", CMD_OK, 1);
      chk("long", LONG_MESSAGE_ENABLE, 1);
      $display("length test done");
      // old address is compared while the header change lands
      {RX_MSG_START, RX_DEST, HDR_CHANGED, HDR_SOURCE} = {1'b1, 8'hF1, 1'b1, 8'h5A};
      @(negedge CLK_SYS);
      {RX_MSG_START, HDR_CHANGED} = 0;
      chk("accept", RX_ACCEPT, 1);
      chk("rxaddr", RX_ADDR, 8'h5A);
      $display("address test done");
      cmd(5'h0B, 8'h01);
      for (k = 0; k < 2; k++) begin
         host_ok = k[0];
         cmd(5'h0A, 8'h23);
         chk("div", BAUD_DIV, 8'h68);
         repeat (4) @(negedge CLK_SYS);
         chk("id", SEND_ID, 1);
         chk("div", BAUD_DIV, 8'h23);
         repeat (12) @(negedge CLK_SYS);
         chk("div", BAUD_DIV, k ? 8'h23 : 8'h68);
      end
      cmd(5'h12, 0);
      chk("div", BAUD_DIV, 8'h23);
      cmd(5'h14, 0);
      chk("div", BAUD_DIV, 8'h68);
      $display("rate test done");
      @(negedge CLK_SYS) MSG_START = 1;
      @(negedge CLK_SYS) {MSG_START, MSG_BYTE_VALID} = 2'b01;
      for (i = 0; i < 14; i++) begin
         MSG_BYTE = 8'hA0 + i[7:0];
         @(negedge CLK_SYS);
      end
      MSG_BYTE_VALID = 0;
      cmd(5'h08, 0);
      for (i = 0; i < 13; i++) begin
         chk("dump", DUMP_BYTE, i == 0 ? 12'h00E : 12'h09F + i[11:0]);
         @(negedge CLK_SYS);
      end
      chk("dvalid", DUMP_VALID, 0);
      $display("dump test done");
      can(0, 8'h10);
      chk("lenline", CAN_LEN_LINE, 1);
      chk("total", CAN_TOTAL_LEN, 12'h014);
      chk("fc", CAN_SEND_FC, 1);
      MONITOR = 1;
      can(0, 8'h10);
      chk("fc", CAN_SEND_FC, 0);
      can(0, 8'h50);
      chk("derr", CAN_DATA_ERR, 1);
      MONITOR = 0;
      can(0, 8'h21);
      chk("strip", CAN_STRIP, 1);
      chk("segnum", CAN_SEG_NUM, 4'h1);
      can(1, 0);
      chk("rtr", CAN_RTR_PRINT, 0);
      cmd(5'h0C, 0);
      can(1, 0);
      chk("rtr", CAN_RTR_PRINT, 1);
      $display("can test done");
      {TX_REQ, TX_LEN} = {1'h1, 4'h8};
      @(negedge CLK_SYS) TX_LEN = 4'h3;
      chk("txacc", TX_ACCEPT, 0);
      @(negedge CLK_SYS) TX_REQ = 0;
      chk("txacc", TX_ACCEPT, 1);
      chk("txpad", TX_PAD, 5'h05);
      chk("txpci", TX_ADD_PCI, 0);
      cmd(5'h0A, 8'h00);
      chk("err", CMD_ERR, 1);
      cmd(5'h09, 8'h00);
      chk("noinit", PROTO_UP_NOINIT, 1);
      cmd(5'h07, 8'h00);
      {RESP_SEEN, RESP_TIME} = {1'h1, 8'h10};
      @(negedge CLK_SYS) RESP_TIME = 8'h40;
      chk("teff", TIMEOUT_EFF, 8'h12);
      @(negedge CLK_SYS) {RESP_SEEN, PROTO_J1939} = 2'h1;
      chk("teff", TIMEOUT_EFF, 8'h32);
      @(negedge CLK_SYS) PROTO_J1939 = 0;
      chk("teff", TIMEOUT_EFF, 8'h4B);
      cmd(5'h05, 8'h00);
      {RESP_SEEN, RESP_TIME} = {1'h1, 8'h10};
      @(negedge CLK_SYS) RESP_SEEN = 0;
      chk("teff", TIMEOUT_EFF, 8'h32);
      $display("timing test done");
      summarize();
   end
endmodule
